// >>> src/psd_slave.sv
// Purpose: Slave end of a DDR byte bus on a self-refreshing DRAM.
// Assumes: The host clock and select arrive as pins, far below CLK_I.
// Notes:   Bus edges are found by sampling the host clock.
//
// How it works
// - Refresh starts internally only while bus idles
// - Strobe high in command phase when refresh pending
// - Select, six command bytes, latency, then data
// - Read strobe toggles with each data byte
// - Write mask high keeps byte, low writes
// - One word per clock, one byte per edge
// - Next word each clock, type per transaction
// - Wrapped burst circles its aligned group
// - Linear burst increments until select released
// - Linear burst prefetches next row early
// - Addresses are word addresses only
// - Row, type from early bytes, column third
// - Reset low returns standby, lanes released
`default_nettype none

module psd_slave (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic CS_N_I,
  input wire logic BUS_CK_I,
  input wire logic STRB_I,
  input wire logic [7:0] DQ_I,
  output logic [7:0] DQ_O,
  output logic DQ_OE_N_O,
  output logic STRB_O,
  output logic STRB_OE_N_O,
  output logic REFRESH_BUSY_O
);

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  psd_pkg::psd_pins_t raw;  // Pins grouped as they arrive
  psd_pkg::psd_pins_t s;    // Pins after two flops

  assign raw = '{cs_n: CS_N_I, ck: BUS_CK_I, strb: STRB_I, dq: DQ_I};

  // Data and clock pass equal delay, so their alignment is kept
  psd_sync u_sync (
    .clk_i(CLK_I),
    .d_i(raw),
    .q_o(s)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Row part of a word address
  function automatic logic [psd_pkg::ROW_W-1:0] psd_row(
    input logic [psd_pkg::ADDR_W-1:0] a
  );
    return a[psd_pkg::ADDR_W-1:psd_pkg::COL_W];
  endfunction : psd_row

  // Next burst address; a wrapped burst keeps the group bits
  function automatic logic [psd_pkg::ADDR_W-1:0] psd_step(
    input logic [psd_pkg::ADDR_W-1:0] a,
    input logic lin
  );
    logic [psd_pkg::ADDR_W-1:0] n;
    n = a + 8'h01;
    if (!lin) begin
      n[psd_pkg::ADDR_W-1:psd_pkg::WRAP_W] =
        a[psd_pkg::ADDR_W-1:psd_pkg::WRAP_W];
    end
    return n;
  endfunction : psd_step

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic sel;                    // Select asserted after sync
  logic ck_prev;                // Host clock one cycle earlier
  logic ck_edge;                // Either host clock edge seen
  logic ref_flag;               // Refresh owed or running
  psd_pkg::psd_state_t st, next_st;      // Transaction phase
  logic [psd_pkg::CA_W-1:0] ca, next_ca; // Command bytes so far
  logic [psd_pkg::CA_W-1:0] ca_full;     // With the current byte
  logic [psd_pkg::CNT_W-1:0] cnt, next_cnt;  // Byte or edge count
  logic [psd_pkg::ADDR_W-1:0] addr, next_addr;  // Current word
  logic is_rd, next_rd;         // Read transaction
  logic is_lin, next_lin;       // Linear burst
  logic extra, next_extra;      // Doubled latency flagged
  logic hi, next_hi;            // Next byte is the upper one
  logic [7:0] next_dq;          // Read byte for the lanes
  logic next_dq_oe_n;           // Lane enable, low drives
  logic next_strb;              // Strobe level
  logic next_strb_oe_n;         // Strobe enable, low drives
  logic [psd_pkg::ROW_W-1:0] open_row, next_open_row;  // Row in use
  logic [psd_pkg::ROW_W-1:0] pf_row, next_pf_row;  // Fetched ahead
  logic pf_valid, next_pf_valid;  // Prefetched row ready
  logic adv;                    // Word finished, step address
  logic mem_we;                 // Write one byte of the array
  logic [psd_pkg::WORD_W-1:0] rd_word;  // Word under the address
  logic [psd_pkg::WORD_W-1:0] mem [psd_pkg::WORDS];  // Array
  logic [psd_pkg::REF_W-1:0] ref_cnt, next_ref_cnt;  // Interval
  logic [psd_pkg::REF_W-1:0] ref_left, next_ref_left;  // Busy time
  logic ref_due, next_ref_due;  // Refresh owed
  logic ref_busy, next_ref_busy;  // Refresh running
  logic ref_go;                 // Refresh starts this cycle

  assign sel = !s.cs_n;
  assign ck_edge = s.ck ^ ck_prev;
  assign ref_flag = ref_due | ref_busy;
  assign ca_full = {ca[psd_pkg::CA_W-psd_pkg::DQ_W-1:0], s.dq};
  assign rd_word = mem[addr];

  // ****************************************************************
  // Refresh engine
  // ****************************************************************
  // Counts the interval; starts refresh only with the bus idle
  always_comb begin
    next_ref_cnt = ref_cnt + 8'h01;
    next_ref_due = ref_due;
    next_ref_busy = ref_busy;
    next_ref_left = ref_left;
    ref_go = ref_due && !ref_busy && st == psd_pkg::ST_IDLE
      && !sel;
    if (ref_go) begin
      next_ref_busy = 1'b1;
      next_ref_left = psd_pkg::REF_BUSY_CYC;
    end else if (ref_busy) begin
      next_ref_left = ref_left - 8'h01;
      if (ref_left == 8'h01) begin
        next_ref_busy = 1'b0;
        next_ref_due = 1'b0;
      end
    end
    // A new interval ending now beats the clear above
    if (ref_cnt == psd_pkg::REF_INT_CYC - 8'h01) begin
      next_ref_cnt = 8'h00;
      next_ref_due = 1'b1;
    end
  end

  // Registers the refresh state
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      ref_cnt <= 8'h00;
      ref_left <= 8'h00;
      ref_due <= 1'b0;
      ref_busy <= 1'b0;
      REFRESH_BUSY_O <= 1'b0;
    end else begin
      ref_cnt <= next_ref_cnt;
      ref_left <= next_ref_left;
      ref_due <= next_ref_due;
      ref_busy <= next_ref_busy;
      REFRESH_BUSY_O <= next_ref_busy;
    end
  end

  // ****************************************************************
  // Transaction engine
  // ****************************************************************
  // Walks command, latency and data phases on host clock edges
  always_comb begin
    next_st = st;
    next_ca = ca;
    next_cnt = cnt;
    next_addr = addr;
    next_rd = is_rd;
    next_lin = is_lin;
    next_extra = extra;
    next_hi = hi;
    next_dq = DQ_O;
    next_dq_oe_n = DQ_OE_N_O;
    next_strb = STRB_O;
    next_strb_oe_n = STRB_OE_N_O;
    next_open_row = open_row;
    next_pf_row = pf_row;
    next_pf_valid = pf_valid;
    adv = 1'b0;
    mem_we = 1'b0;
    if (!sel) begin
      // Select high ends any transaction and frees the lanes
      next_st = psd_pkg::ST_IDLE;
      next_dq_oe_n = 1'b1;
      next_strb_oe_n = 1'b1;
      next_strb = 1'b0;
    end else begin
      unique case (st)
        psd_pkg::ST_IDLE: begin
          // Flag a pending refresh on the strobe at once
          next_st = psd_pkg::ST_CA;
          next_cnt = 4'h0;
          next_extra = ref_flag;
          next_strb = ref_flag;
          next_strb_oe_n = 1'b0;
        end
        psd_pkg::ST_CA: begin
          if (ck_edge) begin
            next_ca = ca_full;
            next_cnt = cnt + 4'h1;
            if (cnt == psd_pkg::CA_LAST) begin
              // Type and row from early bytes, column from last
              next_rd = ca_full[psd_pkg::CA_RW_BIT];
              next_lin = ca_full[psd_pkg::CA_LIN_BIT];
              next_addr = {
                ca_full[psd_pkg::CA_ROW_LSB +: psd_pkg::ROW_W],
                ca_full[psd_pkg::CA_COL_LSB +: psd_pkg::COL_W]
              };
              next_open_row =
                ca_full[psd_pkg::CA_ROW_LSB +: psd_pkg::ROW_W];
              next_pf_valid = 1'b0;
              next_cnt = extra ? psd_pkg::LAT_TWO : psd_pkg::LAT_ONE;
              next_st = psd_pkg::ST_LAT;
              next_strb = 1'b0;
              // A write hands the strobe to the host as a mask
              next_strb_oe_n = !ca_full[psd_pkg::CA_RW_BIT];
            end
          end
        end
        psd_pkg::ST_LAT: begin
          if (ck_edge) begin
            next_cnt = cnt - 4'h1;
            if (cnt == 4'h1) begin
              next_st = is_rd ? psd_pkg::ST_READ : psd_pkg::ST_WRITE;
              next_hi = 1'b1;
              next_dq_oe_n = !is_rd;
            end
          end
        end
        psd_pkg::ST_READ: begin
          if (ck_edge) begin
            // Byte and strobe change together: edge aligned
            next_dq = hi ? rd_word[15:8] : rd_word[7:0];
            next_strb = hi;
            next_hi = !hi;
            adv = !hi;
          end
        end
        psd_pkg::ST_WRITE: begin
          if (ck_edge) begin
            mem_we = !s.strb;
            next_hi = !hi;
            adv = !hi;
          end
        end
      endcase
    end
    // Step the word; a new row takes over the prefetched one
    if (adv) begin
      next_addr = psd_step(addr, is_lin);
      if (psd_row(next_addr) != psd_row(addr)) begin
        next_open_row = psd_row(next_addr);
        next_pf_valid = 1'b0;
      end
    end
    // From halfway through a row, open the next one in the background;
    // a burst that starts late in a row must still fetch before crossing
    if (sel && is_lin && !pf_valid && addr[2:0] >= psd_pkg::COL_MID
        && (st == psd_pkg::ST_READ || st == psd_pkg::ST_WRITE)) begin
      next_pf_row = psd_row(addr) + 5'h01;
      next_pf_valid = 1'b1;
    end
  end

  // Registers the transaction state; reset frees the lanes
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      st <= psd_pkg::ST_IDLE;
      ca <= 48'h000000000000;
      cnt <= 4'h0;
      addr <= 8'h00;
      is_rd <= 1'b0;
      is_lin <= 1'b0;
      extra <= 1'b0;
      hi <= 1'b1;
      ck_prev <= 1'b0;
      open_row <= 5'h00;
      pf_row <= 5'h00;
      pf_valid <= 1'b0;
      DQ_O <= 8'h00;
      DQ_OE_N_O <= 1'b1;
      STRB_O <= 1'b0;
      STRB_OE_N_O <= 1'b1;
    end else begin
      st <= next_st;
      ca <= next_ca;
      cnt <= next_cnt;
      addr <= next_addr;
      is_rd <= next_rd;
      is_lin <= next_lin;
      extra <= next_extra;
      hi <= next_hi;
      ck_prev <= s.ck;
      open_row <= next_open_row;
      pf_row <= next_pf_row;
      pf_valid <= next_pf_valid;
      DQ_O <= next_dq;
      DQ_OE_N_O <= next_dq_oe_n;
      STRB_O <= next_strb;
      STRB_OE_N_O <= next_strb_oe_n;
    end
  end

  // ****************************************************************
  // Array
  // ****************************************************************
  // Byte writes; the array keeps its content through reset
  always_ff @(posedge CLK_I) begin
    if (mem_we) begin
      if (hi) begin
        mem[addr][15:8] <= s.dq;
      end else begin
        mem[addr][7:0] <= s.dq;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  // Command phase followed by the latency phase; ca_count_a checks the count
  sequence ca_to_lat;
    st == psd_pkg::ST_CA ##1 st == psd_pkg::ST_LAT;
  endsequence

  // Read edge seen while selected in the read phase
  sequence read_edge;
    sel && st == psd_pkg::ST_READ && ck_edge;
  endsequence

  lanes_idle_a: assert property (
    s.cs_n |=> DQ_OE_N_O && STRB_OE_N_O)
    else $error("lanes driven with select high");

  reset_release_a: assert property (
    @(posedge CLK_I) disable iff (1'b0)
    !RSTN_I |=> DQ_OE_N_O && STRB_OE_N_O && st == psd_pkg::ST_IDLE)
    else $error("reset left lanes driven");

  refresh_idle_a: assert property (
    ref_go |-> st == psd_pkg::ST_IDLE && s.cs_n ##1 ref_busy)
    else $error("refresh started during a transaction");

  latency_flag_a: assert property (
    $rose(st == psd_pkg::ST_CA) |->
      !STRB_OE_N_O && STRB_O == $past(ref_flag))
    else $error("strobe does not flag pending refresh");

  ca_count_a: assert property (
    ca_to_lat |->
      cnt == (extra ? psd_pkg::LAT_TWO : psd_pkg::LAT_ONE))
    else $error("wrong latency after command phase");

  read_strobe_a: assert property (
    read_edge |=> STRB_O != $past(STRB_O) && !DQ_OE_N_O)
    else $error("read strobe did not toggle");

  wrap_group_a: assert property (
    adv && !is_lin |=> addr[7:2] == $past(addr[7:2])
      && addr[1:0] == $past(addr[1:0]) + 2'h1)
    else $error("wrapped burst left its group");

  linear_step_a: assert property (
    adv && is_lin |=> addr == $past(addr) + 8'h01)
    else $error("linear burst did not increment");

  prefetch_ready_a: assert property (
    adv && is_lin && addr[2:0] == 3'h7 |->
      pf_valid && pf_row == psd_row(addr) + 5'h01)
    else $error("row crossed without prefetch");

  mask_keep_a: assert property (
    sel && st == psd_pkg::ST_WRITE && ck_edge && s.strb |-> !mem_we)
    else $error("masked byte written");

endmodule : psd_slave

`default_nettype wire

// >>> include/psd_pkg.sv
// Purpose: Shared constants and types for the DDR pseudo-static RAM slave.
// Assumes: One 20 MHz system clock samples every bus pin.
// Notes:   Latencies are counted in bus clock edges, refresh in CLK_I cycles.
`default_nettype none

package psd_pkg;

  // ****************************************************************
  // Widths of the bus, the word and the array
  // ****************************************************************
  localparam int DQ_W = 8;                // Data lanes per bus edge
  localparam int WORD_W = 16;             // Core word per bus clock
  localparam int CA_W = 48;               // Command/address field
  localparam int ROW_W = 5;               // Row index width
  localparam int COL_W = 3;               // Word within row
  localparam int ADDR_W = ROW_W + COL_W;  // Word address, no byte bit
  localparam int WORDS = 256;             // Array depth in words
  localparam int WRAP_W = 2;              // Wrap group of four words
  localparam int CNT_W = 4;               // Phase counter width
  localparam int REF_W = 8;               // Refresh counter width

  // ****************************************************************
  // Command/address field positions
  // ****************************************************************
  localparam int CA_RW_BIT = 47;          // High means read
  localparam int CA_LIN_BIT = 45;         // High means linear burst
  localparam int CA_ROW_LSB = 16;         // Row sits in the first cycles
  localparam int CA_COL_LSB = 0;          // Column sits in the third

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;      // CLK_I period
  localparam int CA_BYTES = 6;            // Bytes of command/address
  localparam int INIT_LAT_CK = 3;         // Initial access, bus clocks
  localparam int REFRESH_INTERVAL_NS = 4000;  // Longest gap
  localparam int REFRESH_BUSY_NS = 200;   // Least refresh duration
  localparam logic [CNT_W-1:0] CA_LAST = CNT_W'(CA_BYTES - 1);
  localparam logic [CNT_W-1:0] LAT_ONE = CNT_W'(2 * INIT_LAT_CK);
  localparam logic [CNT_W-1:0] LAT_TWO = CNT_W'(4 * INIT_LAT_CK);
  localparam logic [REF_W-1:0] REF_INT_CYC =
    REF_W'(REFRESH_INTERVAL_NS / CLK_PERIOD_NS);
  localparam logic [REF_W-1:0] REF_BUSY_CYC =
    REF_W'((REFRESH_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [COL_W-1:0] COL_MID = 3'h4;  // Prefetch point in row

  // ****************************************************************
  // Types
  // ****************************************************************
  // Bus pins as seen after the synchroniser
  typedef struct packed {
    logic cs_n;
    logic ck;
    logic strb;
    logic [DQ_W-1:0] dq;
  } psd_pins_t;

  // Transaction phase
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CA,
    ST_LAT,
    ST_READ,
    ST_WRITE
  } psd_state_t;

endpackage : psd_pkg

`default_nettype wire

// >>> src/psd_sync.sv
// Purpose: Two-flop synchroniser for the bus pins.
// Assumes: Every bit is an independent level from outside CLK_I.
// Notes:   The first stage feeds only the second stage.
`default_nettype none

module psd_sync (
  input wire logic clk_i,
  input wire psd_pkg::psd_pins_t d_i,
  output var psd_pkg::psd_pins_t q_o
);

  // ****************************************************************
  // Two stages
  // ****************************************************************
  psd_pkg::psd_pins_t meta;  // Possibly metastable, read by q_o only

  // Registers both stages; reset is not needed, the pins settle fast
  always_ff @(posedge clk_i) begin
    meta <= d_i;
    q_o <= meta;
  end

endmodule : psd_sync

`default_nettype wire

// >>> bench/psd_host.sv
// Purpose: Host bus master model that drives select, bus clock and lanes.
// Assumes: Stimulus moves on the falling edge of clk_i.
// Notes:   One bus half period lasts six clk_i cycles.
`default_nettype none

module psd_host (
  input wire logic clk_i,
  input wire logic [7:0] dev_dq_i,
  input wire logic dev_dq_oe_n_i,
  input wire logic dev_strb_i,
  input wire logic dev_strb_oe_n_i,
  output logic cs_n_o,
  output logic ck_o,
  output logic strb_o,
  output logic [7:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] h_dq = 8'h00;  // Last byte the host put on the lanes
  logic h_strb = 1'b0;       // Last mask level from the host
  logic h_en = 1'b0;         // High while the host drives lanes and mask

  // Idle bus: deselected, clock parked low
  initial begin
    cs_n_o = 1'b1;
    ck_o = 1'b0;
  end

  // Wire level: a released line shows the inverse of its last value,
  // so a device that reads a floating lane cannot pass by luck
  assign dq_o = !dev_dq_oe_n_i ? dev_dq_i : (h_en ? h_dq : ~h_dq);
  assign strb_o = !dev_strb_oe_n_i ? dev_strb_i :
                  (h_en ? h_strb : ~h_strb);

  // One bus edge, byte held three cycles either side of the change
  task automatic bus_edge(input logic [7:0] d, input logic m,
                          input logic en);
    h_dq = d;
    h_strb = m;
    h_en = en;
    repeat (3) @(negedge clk_i);
    ck_o = ~ck_o;
    repeat (3) @(negedge clk_i);
  endtask : bus_edge

  // Select with the clock low, wait, sample the flag, send six bytes
  task automatic open_bus(input logic [47:0] ca, input int pre,
                          output logic flag, output logic flag_oe_n);
    @(negedge clk_i);
    cs_n_o = 1'b0;
    repeat (pre) @(negedge clk_i);
    flag = dev_strb_i;
    flag_oe_n = dev_strb_oe_n_i;
    for (int i = 5; i >= 0; i--) begin
      bus_edge(ca[i*8 +: 8], 1'b0, 1'b1);
    end
  endtask : open_bus

  // End the transaction; bursts stay short for refresh
  task automatic close_bus();
    cs_n_o = 1'b1;
    h_en = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask : close_bus

endmodule : psd_host

`default_nettype wire

// >>> bench/tb_top.sv
// Purpose: Self-checking bench for the DDR pseudo-static RAM slave.
// Assumes: Inputs move at the falling edge; one 20 MHz clock.
// Notes:   Expected array content is kept in a local word model.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;         // System clock
  logic rstn = 1'b0;        // Reset, active low
  logic cs_n;               // Select from the host model
  logic bus_ck;             // Bus clock from the host model
  logic strb_in;            // Resolved strobe/mask wire
  logic [7:0] dq_in;        // Resolved lane wire
  logic [7:0] dq_out;       // Device read byte
  logic dq_oe_n;            // Device lane enable
  logic strb_out;           // Device strobe
  logic strb_oe_n;          // Device strobe enable
  logic ref_busy;           // Internal refresh running
  logic [15:0] mem [256];   // Expected array content
  logic [15:0] wd [4];      // Words for the next write
  logic [1:0] mk [4];       // Byte masks for the next write
  logic fl;                 // Refresh flag seen by the host
  int miscompares = 0;
  int n_compared = 0;

  // Clock: 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end

  psd_slave i_psd_slave (
    .CLK_I(clk), .RSTN_I(rstn), .CS_N_I(cs_n), .BUS_CK_I(bus_ck),
    .STRB_I(strb_in), .DQ_I(dq_in), .DQ_O(dq_out),
    .DQ_OE_N_O(dq_oe_n), .STRB_O(strb_out), .STRB_OE_N_O(strb_oe_n),
    .REFRESH_BUSY_O(ref_busy)
  );

  psd_host i_psd_host (
    .clk_i(clk), .dev_dq_i(dq_out), .dev_dq_oe_n_i(dq_oe_n),
    .dev_strb_i(strb_out), .dev_strb_oe_n_i(strb_oe_n), .cs_n_o(cs_n),
    .ck_o(bus_ck), .strb_o(strb_in), .dq_o(dq_in)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  // One whole transaction; the latency follows the flag seen
  task automatic xfer(input logic rd, input logic lin, input logic [7:0] a,
                      input int n, input int pre, output logic flag);
    logic [47:0] ca;
    logic fl_oe_n;
    logic [15:0] w;
    ca = 48'h0;
    ca[47] = rd;
    ca[45] = lin;
    ca[20:16] = a[7:3];
    ca[2:0] = a[2:0];
    i_psd_host.open_bus(ca, pre, flag, fl_oe_n);
    check("flag_oe_n", {15'h0, fl_oe_n}, 16'h0000);
    if (!rd) check("wr_strb_oe_n", {15'h0, strb_oe_n}, 16'h0001);
    // Host honours the longer wait when flagged
    repeat ((flag === 1'b1 ? 4 : 2) * psd_pkg::INIT_LAT_CK) begin
      i_psd_host.bus_edge(8'hA5, 1'b0, !rd);
    end
    for (int k = 0; k < n; k++) begin
      if (rd) begin
        i_psd_host.bus_edge(8'h00, 1'b0, 1'b0);
        w[15:8] = dq_out;
        check("rd_strb_hi", {15'h0, strb_out}, 16'h0001);
        check("rd_oe_n", {15'h0, dq_oe_n}, 16'h0000);
        i_psd_host.bus_edge(8'h00, 1'b0, 1'b0);
        w[7:0] = dq_out;
        check("rd_strb_lo", {15'h0, strb_out}, 16'h0000);
        check("rd_word", w, mem[a]);
        check("busy_in_burst", {15'h0, ref_busy}, 16'h0000);
      end else begin
        i_psd_host.bus_edge(wd[k][15:8], mk[k][1], 1'b1);
        i_psd_host.bus_edge(wd[k][7:0], mk[k][0], 1'b1);
        // Masked bytes keep their old content
        if (!mk[k][1]) mem[a][15:8] = wd[k][15:8];
        if (!mk[k][0]) mem[a][7:0] = wd[k][7:0];
      end
      a = lin ? a + 8'h01 : {a[7:2], a[1:0] + 2'h1};
    end
    i_psd_host.close_bus();
    check("idle_dq_oe_n", {15'h0, dq_oe_n}, 16'h0001);
    check("idle_strb_oe_n", {15'h0, strb_oe_n}, 16'h0001);
  endtask : xfer

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    check("rst_dq_oe_n", {15'h0, dq_oe_n}, 16'h0001);
    check("rst_strb_oe_n", {15'h0, strb_oe_n}, 16'h0001);
    check("rst_busy", {15'h0, ref_busy}, 16'h0000);
  endtask : t_reset

  // Select falls while the first refresh runs, so it must be flagged
  task automatic t_flag_write();
    wd = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
    mk = '{2'b00, 2'b00, 2'b00, 2'b00};
    for (int i = 0; i < 100 && ref_busy !== 1'b1; i++) @(negedge clk);
    check("busy_before_flag", {15'h0, ref_busy}, 16'h0001);
    xfer(1'b0, 1'b0, 8'h11, 4, 100, fl);
    check("flag_pending", {15'h0, fl}, 16'h0001);
  endtask : t_flag_write

  // Deferred refresh runs once idle, for its fixed length
  task automatic t_refresh();
    int cnt;
    cnt = 0;
    for (int i = 0; i < 40 && ref_busy !== 1'b1; i++) @(negedge clk);
    while (ref_busy === 1'b1 && cnt < 20) begin
      cnt++;
      @(negedge clk);
    end
    check("refresh_len", 16'(cnt), {8'h00, psd_pkg::REF_BUSY_CYC});
  endtask : t_refresh

  // Upper byte masked over a word already written
  task automatic t_mask_write();
    wd[0] = 16'hABCD;
    mk[0] = 2'b10;
    xfer(1'b0, 1'b1, 8'h12, 1, 4, fl);
  endtask : t_mask_write

  // Read wraps inside the aligned group of four
  task automatic t_wrap_read();
    xfer(1'b1, 1'b0, 8'h11, 4, 4, fl);
  endtask : t_wrap_read

  // Linear write and read across a row boundary
  task automatic t_linear();
    wd = '{16'h5A01, 16'h5A02, 16'h5A03, 16'h5A04};
    mk = '{2'b00, 2'b00, 2'b00, 2'b00};
    xfer(1'b0, 1'b1, 8'h1E, 4, 4, fl);
    xfer(1'b1, 1'b1, 8'h1E, 4, 4, fl);
  endtask : t_linear

  // Reset in mid-transaction releases both lanes
  task automatic t_mid_reset();
    logic f_oe_n;
    i_psd_host.open_bus(48'h800000000011, 4, fl, f_oe_n);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    check("mid_dq_oe_n", {15'h0, dq_oe_n}, 16'h0001);
    check("mid_strb_oe_n", {15'h0, strb_oe_n}, 16'h0001);
    // Select must be seen high before reset lets go
    i_psd_host.close_bus();
    rstn = 1'b1;
    xfer(1'b1, 1'b0, 8'h11, 1, 4, fl);
  endtask : t_mid_reset

  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    t_reset();
    t_flag_write();
    t_refresh();
    t_mask_write();
    t_wrap_read();
    t_linear();
    t_mid_reset();
    end_sim();
  end

  // Hang guard: a run this long counts as a failure
  initial begin
    repeat (60000) @(negedge clk);
    miscompares++;
    end_sim();
  end

endmodule : tb_top

`default_nettype wire
